/* File: rtl/spr_pkg.sv */
`default_nettype none
package spr_pkg;
  localparam int SPR_BITS = 8;
  localparam int SPR_DIV_W = 8;
  localparam logic [7:0] SPR_DIV_ONE = 8'h01;
  localparam logic SPR_TRANSMIT_EMPTY_FLAG_RST = 1'b1;
  localparam logic SPR_CS_IDLE = 1'b1;
  localparam int SPR_GLITCH_EDGES = 2;

  typedef struct packed {
    logic master;
    logic clock_polarity_bit;
    logic clock_phase_bit;
    logic keep_select_after_transfer;
    logic mode_fault_detect_disable;
  } spr_cfg_s;

  typedef struct packed {
    logic valid;
    logic [SPR_BITS-1:0] data;
  } spr_wr_s;

  typedef enum logic [1:0] {
    SPR_IDLE,
    SPR_GLITCH,
    SPR_SHIFT
  } spr_state_e;
endpackage
`default_nettype wire

/* File: rtl/spr_core.sv */
`timescale 1ns/1ns
`default_nettype none
module spr_core #(
  parameter int DW = spr_pkg::SPR_BITS
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic enable_cmd,
  input wire logic disable_cmd,
  input wire spr_pkg::spr_cfg_s cfg,
  input wire logic [7:0] serial_clock_divisor_0,
  input wire logic [7:0] serial_clock_divisor_1,
  input wire logic cs_sel,
  input wire spr_pkg::spr_wr_s tdr_wr,
  input wire logic rx_read,
  input wire logic miso_in,
  input wire logic nss_in,
  input wire logic slave_sck,
  input wire logic slave_cs_n,
  input wire logic slave_mosi,
  output logic unit_enabled,
  output logic transmit_empty_flag,
  output logic receive_ready_flag,
  output logic [DW-1:0] receive_holding_register,
  output logic mode_fault,
  output logic sck_out,
  output logic mosi_out,
  output logic [1:0] cs_n_out,
  output logic slave_miso_out,
  output logic slave_miso_oe
);
  import spr_pkg::*;
  localparam int HW = $clog2(2 * DW);
  localparam logic [HW-1:0] HB_LAST = HW'(2 * DW - 1);
  localparam logic [$clog2(DW)-1:0] SB_LAST = ($clog2(DW))'(DW - 1);

  function automatic logic [7:0] eff_div(input logic [7:0] d);
    eff_div = (d == 8'h00) ? SPR_DIV_ONE : d;
  endfunction

  // Core domain state.
  logic enabled_r, transmit_empty_flag_r, rxrdy_r, modf_r;
  logic [DW-1:0] tdr_r, rhr_r, slv_tx_r, tx_sh_r, rx_sh_r;
  spr_state_e st_r;
  logic [7:0] cnt_r;
  logic [HW-1:0] hb_r;
  logic sck_r, mosi_r;
  logic [1:0] cs_n_r;
  logic miso_s1, miso_s2, nss_s1, nss_s2, sck_s1, sck_s2;
  logic rxt_s1, rxt_s2, rxt_s3, ldt_s1, ldt_s2, ldt_s3;
  // Link domain state.
  logic [$clog2(DW)-1:0] sb_r;
  logic [DW-1:0] sr_r, sword_r, stx_r;
  logic rxtog_r, ldtog_r, smiso_r, soe_r;

  wire [7:0] div_cur = eff_div(cs_sel ? serial_clock_divisor_1
                                      : serial_clock_divisor_0);
  wire one0 = eff_div(serial_clock_divisor_0) == SPR_DIV_ONE;
  wire one1 = eff_div(serial_clock_divisor_1) == SPR_DIV_ONE;
  wire mixed_glitch = cfg.clock_polarity_bit & ~cfg.clock_phase_bit &
                      (one0 != one1);
  wire blocked = cfg.keep_select_after_transfer & ~cs_sel &
                 ~cfg.mode_fault_detect_disable;
  wire wr_ok = tdr_wr.valid & enabled_r;
  wire tick = cnt_r == div_cur - 8'h01;
  wire m_start = cfg.master & enabled_r & (st_r == SPR_IDLE) & ~transmit_empty_flag_r &
                 ~blocked;
  wire slv_rx_evt = rxt_s2 ^ rxt_s3;
  wire slv_ld_evt = ldt_s2 ^ ldt_s3;
  wire s_load = ~cfg.master & enabled_r & slv_ld_evt & ~transmit_empty_flag_r;
  wire load = m_start | s_load;
  wire samp = hb_r[0] == cfg.clock_phase_bit;
  wire [DW-1:0] rx_new = {rx_sh_r[DW-2:0], miso_s2};
  wire m_done = (st_r == SPR_SHIFT) & tick & (hb_r == HB_LAST);
  wire spur = ~cfg.master & enable_cmd & ~enabled_r &
              (sck_s2 != cfg.clock_polarity_bit);
  wire fault = cfg.master & enabled_r & ~nss_s2 &
               ~cfg.mode_fault_detect_disable;
  wire keep = cfg.keep_select_after_transfer & ~cs_sel;

  // Disable only acts in master mode; a fault also drops the enable.
  wire enabled_nxt = soft_reset ? 1'b0 :
                     enable_cmd ? 1'b1 :
                     ((disable_cmd & cfg.master) | fault) ? 1'b0 :
                     enabled_r;
  // A write and a load in one cycle leave the new word waiting.
  wire transmit_empty_flag_nxt = soft_reset ? SPR_TRANSMIT_EMPTY_FLAG_RST :
                  wr_ok ? 1'b0 : load ? 1'b1 : transmit_empty_flag_r;
  wire rx_set = m_done | (~cfg.master & enabled_r & slv_rx_evt) | spur;
  wire rxrdy_nxt = soft_reset ? 1'b0 : rx_set ? 1'b1 :
                   rx_read ? 1'b0 : rxrdy_r;
  wire [DW-1:0] rhr_nxt = m_done ? (samp ? rx_new : rx_sh_r) :
                          (rx_set & ~spur) ? sword_r : rhr_r;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {miso_s1, miso_s2, nss_s1, nss_s2, sck_s1, sck_s2} <= 6'h3F;
      {rxt_s1, rxt_s2, rxt_s3, ldt_s1, ldt_s2, ldt_s3} <= 6'h00;
    end else begin
      {miso_s2, miso_s1} <= {miso_s1, miso_in};
      {nss_s2, nss_s1} <= {nss_s1, nss_in};
      {sck_s2, sck_s1} <= {sck_s1, slave_sck};
      {rxt_s3, rxt_s2, rxt_s1} <= {rxt_s2, rxt_s1, rxtog_r};
      {ldt_s3, ldt_s2, ldt_s1} <= {ldt_s2, ldt_s1, ldtog_r};
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enabled_r <= 1'b0;
      transmit_empty_flag_r <= SPR_TRANSMIT_EMPTY_FLAG_RST;
      rxrdy_r <= 1'b0;
      modf_r <= 1'b0;
      tdr_r <= '0;
      rhr_r <= '0;
      slv_tx_r <= '0;
    end else begin
      enabled_r <= enabled_nxt;
      transmit_empty_flag_r <= transmit_empty_flag_nxt;
      rxrdy_r <= rxrdy_nxt;
      modf_r <= soft_reset ? 1'b0 : (modf_r | fault);
      tdr_r <= wr_ok ? tdr_wr.data : tdr_r;
      rhr_r <= rhr_nxt;
      // With nothing queued the old word repeats and no flag is raised.
      slv_tx_r <= s_load ? tdr_r : slv_tx_r;
    end
  end

  // Master engine: the serial clock is divided down from core_clk.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= SPR_IDLE;
      cnt_r <= 8'h00;
      hb_r <= '0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      cs_n_r <= {2{SPR_CS_IDLE}};
      tx_sh_r <= '0;
      rx_sh_r <= '0;
    end else if (soft_reset || !enabled_r) begin
      st_r <= SPR_IDLE;
      cnt_r <= 8'h00;
      hb_r <= '0;
      sck_r <= cfg.clock_polarity_bit;
      cs_n_r <= {2{SPR_CS_IDLE}};
    end else begin
      unique case (st_r)
        SPR_IDLE: begin
          cnt_r <= 8'h00;
          hb_r <= '0;
          sck_r <= cfg.clock_polarity_bit;
          if (m_start) begin
            st_r <= mixed_glitch ? SPR_GLITCH : SPR_SHIFT;
            cs_n_r <= cs_sel ? 2'b01 : 2'b10;
            tx_sh_r <= cfg.clock_phase_bit ? tdr_r : tdr_r << 1;
            mosi_r <= cfg.clock_phase_bit ? mosi_r : tdr_r[DW-1];
          end
        end
        SPR_GLITCH: begin
          cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
          if (tick) begin
            sck_r <= ~sck_r;
            hb_r <= hb_r + HW'(1);
            if (hb_r == HW'(SPR_GLITCH_EDGES - 1)) begin
              st_r <= SPR_SHIFT;
              hb_r <= '0;
            end
          end
        end
        SPR_SHIFT: begin
          cnt_r <= tick ? 8'h00 : cnt_r + 8'h01;
          if (tick) begin
            sck_r <= ~sck_r;
            hb_r <= hb_r + HW'(1);
            if (samp) begin
              rx_sh_r <= rx_new;
            end else begin
              mosi_r <= tx_sh_r[DW-1];
              tx_sh_r <= tx_sh_r << 1;
            end
            if (hb_r == HB_LAST) begin
              st_r <= SPR_IDLE;
              cs_n_r <= keep ? cs_n_r : {2{SPR_CS_IDLE}};
            end
          end
        end
      endcase
    end
  end

  // Link side runs on the external master's clock; deselect resets it,
  // so a frame that stops mid-byte cannot leave a stale bit count.
  wire slv_rst_n = rstn & ~slave_cs_n;
  always_ff @(posedge slave_sck or negedge slv_rst_n) begin
    if (!slv_rst_n) begin
      sb_r <= '0;
      sr_r <= '0;
      stx_r <= '0;
      smiso_r <= 1'b0;
      soe_r <= 1'b0;
    end else begin
      soe_r <= 1'b1;
      sb_r <= sb_r + ($clog2(DW))'(1);
      sr_r <= {sr_r[DW-2:0], slave_mosi};
      stx_r <= (sb_r == SB_LAST) ? slv_tx_r : stx_r << 1;
      smiso_r <= (sb_r == SB_LAST) ? slv_tx_r[DW-1] : stx_r[DW-2];
    end
  end

  // Toggles and the received word survive deselect for the core to see.
  always_ff @(posedge slave_sck or negedge rstn) begin
    if (!rstn) begin
      sword_r <= '0;
      rxtog_r <= 1'b0;
      ldtog_r <= 1'b0;
    end else if (!slave_cs_n && sb_r == SB_LAST) begin
      sword_r <= {sr_r[DW-2:0], slave_mosi};
      rxtog_r <= ~rxtog_r;
      ldtog_r <= ~ldtog_r;
    end
  end

  assign unit_enabled = enabled_r;
  assign transmit_empty_flag = transmit_empty_flag_r;
  assign receive_ready_flag = rxrdy_r;
  assign receive_holding_register = rhr_r;
  assign mode_fault = modf_r;
  assign sck_out = sck_r;
  assign mosi_out = mosi_r;
  assign cs_n_out = cs_n_r;
  assign slave_miso_out = smiso_r;
  assign slave_miso_oe = soe_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  disable_slave_held_a: assert property (
    enabled_r && !cfg.master && disable_cmd && !soft_reset |=> enabled_r)
    else $error("Slave mode disable took effect.");
  transmit_empty_flag_write_clear_a: assert property (
    tdr_wr.valid && enabled_r && !soft_reset |=> !transmit_empty_flag_r)
    else $error("Write while enabled did not clear the empty flag.");
  transmit_empty_flag_disabled_a: assert property (
    !enabled_r && !soft_reset |=> $stable(transmit_empty_flag_r) && $stable(tdr_r))
    else $error("Disabled unit changed transmit state.");
  keep_hang_a: assert property (
    st_r == SPR_IDLE && blocked |=> st_r == SPR_IDLE)
    else $error("Transfer began with keep select and fault detect.");
  glitch_pulse_a: assert property (
    m_start && mixed_glitch && !soft_reset |=> st_r == SPR_GLITCH
    ##1 (st_r == SPR_GLITCH)[*1] )
    else $error("Mixed divisors did not produce the extra pulse.");
  spur_ready_a: assert property (
    spur && !soft_reset |=> rxrdy_r)
    else $error("Slave enable did not raise receive ready.");
  underrun_silent_a: assert property (
    slv_ld_evt && transmit_empty_flag_r && !tdr_wr.valid && !soft_reset |=> transmit_empty_flag_r &&
    $stable(slv_tx_r))
    else $error("Slave underrun changed visible state.");
  frame_len_a: assert property (
    st_r == SPR_IDLE ##1 st_r == SPR_SHIFT |-> st_r == SPR_SHIFT [*2])
    else $error("Master frame ended too early.");

  master_frame_c: cover property (m_done);
  slave_byte_c: cover property (!cfg.master && slv_rx_evt && enabled_r);
  glitch_c: cover property (st_r == SPR_GLITCH);
  dropped_write_c: cover property (tdr_wr.valid && !enabled_r);
endmodule
`default_nettype wire

/* File: tb/spr_spi_peer.sv */
`timescale 1ns/1ns
`default_nettype none
module spr_spi_peer (
  output logic sck = 1'b0,
  output logic cs_n = 1'b1,
  output logic mosi = 1'b0
);
  // The link clock runs only inside a frame, as a real master's would.
  task automatic send(input logic [7:0] b);
    #7 cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = b[i];
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #32 cs_n = 1'b1;
    // A released line must not look like a held bit.
    mosi = ~mosi;
  endtask
endmodule
`default_nettype wire

/* File: tb/spi_silicon_revision_behaviour_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module spi_silicon_revision_behaviour_tb;
  import spr_pkg::*;
  logic core_clk, rstn, soft_reset, enable_cmd, disable_cmd, cs_sel;
  logic rx_read, miso_in, nss_in, ena, tef, rrf, mode_fault, sck_out;
  logic mosi_out, s_miso, s_oe, sck_prev, loopback;
  logic [7:0] div0, div1, rhr, b;
  logic [1:0] cs_n_out;
  spr_cfg_s cfg;
  spr_wr_s tdr_wr;
  wire logic p_sck, p_csn, p_mosi;
  int n_mismatch, cmp_count, toggles, t0;
  spr_core i_dut (.core_clk, .rstn, .soft_reset, .enable_cmd, .disable_cmd,
    .cfg, .serial_clock_divisor_0(div0), .serial_clock_divisor_1(div1),
    .cs_sel, .tdr_wr, .rx_read, .miso_in, .nss_in, .slave_sck(p_sck),
    .slave_cs_n(p_csn), .slave_mosi(p_mosi), .unit_enabled(ena),
    .transmit_empty_flag(tef), .receive_ready_flag(rrf),
    .receive_holding_register(rhr), .mode_fault, .sck_out, .mosi_out,
    .cs_n_out, .slave_miso_out(s_miso), .slave_miso_oe(s_oe));
  spr_spi_peer i_peer (.sck(p_sck), .cs_n(p_csn), .mosi(p_mosi));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    // Looping the data line back lets slow frames check both directions.
    miso_in <= loopback ? mosi_out : 1'($urandom);
    if (sck_out !== sck_prev) toggles++;
    sck_prev <= sck_out;
  end
  function automatic int exp_toggles(logic p, logic h, logic [7:0] a,
                                     logic [7:0] c);
    logic one_a, one_c;
    one_a = (a <= 8'h01);
    one_c = (c <= 8'h01);
    return (p && !h && (one_a != one_c)) ? 18 : 16;
  endfunction
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic pulse(input int k);
    @(negedge core_clk);
    case (k)
      0: enable_cmd = 1'b1;
      1: disable_cmd = 1'b1;
      2: soft_reset = 1'b1;
      default: rx_read = 1'b1;
    endcase
    @(negedge core_clk);
    {enable_cmd, disable_cmd, soft_reset, rx_read} = 4'h0;
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge core_clk);
    tdr_wr = {1'b1, d};
    @(negedge core_clk);
    tdr_wr.valid = 1'b0;
  endtask
  task automatic wait_rrf(input int lim);
    for (int n = 0; n < lim && rrf !== 1'b1; n++) @(negedge core_clk);
    check("rx_ready", rrf, 1);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {rstn, soft_reset, enable_cmd, disable_cmd, cs_sel, rx_read} = 6'h0;
    {nss_in, loopback, div0, div1} = {2'b10, 16'h0101};
    cfg = 5'b10001;
    tdr_wr = 9'h000;
    void'($urandom(32'hB8DD));
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    check("rst", {ena, tef, rrf, cs_n_out}, 5'b01011);
    pulse(0);
    for (int i = 0; i < 6; i++) begin
      cfg.clock_polarity_bit = (i < 2) ? 1'b1 : 1'($urandom);
      cfg.clock_phase_bit = (i < 2) ? 1'b0 : 1'($urandom);
      div0 = (i < 2) ? 8'h01 : 8'($urandom_range(0, 4));
      div1 = (i == 0) ? 8'h03 : (i == 1) ? 8'h01 : 8'($urandom_range(3, 4));
      cs_sel = (i == 2) ? 1'b1 : 1'($urandom);
      // The input synchroniser needs three cycles per half clock to loop.
      loopback = ((cs_sel ? div1 : div0) >= 8'h03);
      repeat (3) @(negedge core_clk);
      t0 = toggles;
      b = 8'($urandom);
      wr(b);
      check("tef_wr", tef, 0);
      wait_rrf(600);
      if (loopback) check("m_rx", rhr, b);
      repeat (12) @(negedge core_clk);
      check("toggles", toggles - t0, exp_toggles(cfg.clock_polarity_bit,
        cfg.clock_phase_bit, div0, div1));
      check("cs_idle", cs_n_out, 2'b11);
      pulse(3);
      check("rrf_rd", rrf, 0);
    end
    pulse(1);
    check("dis", {ena, tef}, 2'b01);
    for (int i = 0; i < 3; i++) begin
      wr(8'($urandom));
      check("dma_drop", {tef, cs_n_out}, 3'b111);
    end
    pulse(0);
    cfg.keep_select_after_transfer = 1'b1;
    cfg.mode_fault_detect_disable = 1'b0;
    cs_sel = 1'b0;
    wr(8'hA5);
    repeat (200) @(negedge core_clk);
    check("hang", {tef, rrf, cs_n_out}, 4'b0011);
    cfg.mode_fault_detect_disable = 1'b1;
    wait_rrf(600);
    check("keep_cs", cs_n_out, 2'b10);
    cfg.mode_fault_detect_disable = 1'b0;
    nss_in = 1'b0;
    repeat (5) @(negedge core_clk);
    check("fault", {mode_fault, ena, cs_n_out}, 4'b1011);
    nss_in = 1'b1;
    pulse(2);
    check("fault_clr", {mode_fault, tef}, 2'b01);
    // Enabling with the line level against the polarity shows the glitch.
    cfg = 5'b01001;
    pulse(0);
    check("spur", rrf, 1);
    cfg.clock_polarity_bit = 1'b0;
    repeat (3) @(negedge core_clk);
    cfg.clock_polarity_bit = 1'b1;
    pulse(3);
    check("no_glitch", rrf, 0);
    pulse(1);
    check("slv_dis", ena, 1);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h80 : 8'($urandom);
      i_peer.send(b);
      wait_rrf(50);
      check("slv_rx", rhr, b);
      pulse(3);
      check("slv_tx", {tef, s_oe, s_miso}, 3'b100);
    end
    pulse(2);
    check("slv_stop", ena, 0);
    close_out();
  end
endmodule
`default_nettype wire
